// file: pkg/tmw_pkg.sv
/*
  Constants for the 16-bit timer wave block: register map, field
  positions, reset values and mode codes.
  Assumes a single AHB-Lite slave with 32-bit data, word registers.
*/
package tmw_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA = 8'h08;
  localparam logic [7:0] ADDR_CMPB = 8'h0c;
  localparam logic [7:0] ADDR_CAPT = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;
  // ****************************************
  // control, flag and port field positions
  // ****************************************
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAPT = 3;
  localparam int PORT_DIR_A = 0;
  localparam int PORT_DIR_B = 1;
  localparam int PORT_DAT_A = 2;
  localparam int PORT_DAT_B = 3;
  // ****************************************
  // values
  // ****************************************
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_CTC_A = 4'h4;
  localparam logic [3:0] WM_FAST_8 = 4'h5;
  localparam logic [3:0] WM_FAST_9 = 4'h6;
  localparam logic [3:0] WM_FAST_10 = 4'h7;
  localparam logic [3:0] WM_CTC_CAP = 4'hc;
  localparam logic [3:0] WM_FAST_CAP = 4'he;
  localparam logic [3:0] WM_FAST_A = 4'hf;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    TMW_NORMAL, TMW_CLEAR_MATCH, TMW_FAST, TMW_OTHER
  } tmw_class_t;

  // sequence class from waveform mode only
  function automatic tmw_class_t tmw_class(input logic [3:0] wm);
    tmw_class_t c;
    c = TMW_OTHER;
    if (wm == WM_NORMAL) begin
      c = TMW_NORMAL;
    end else if (wm == WM_CTC_A || wm == WM_CTC_CAP) begin
      c = TMW_CLEAR_MATCH;
    end else if (wm == WM_FAST_8 || wm == WM_FAST_9 || wm == WM_FAST_10 ||
                 wm == WM_FAST_CAP || wm == WM_FAST_A) begin
      c = TMW_FAST;
    end
    return c;
  endfunction
endpackage

// file: rtl/tmw_wave_out.sv
/*
  One compare output channel: internal wave state and pin mux.
  Assumes match and bottom strobes already qualified by the timer enable.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_wave_out (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // events
  input wire logic match_ev,
  input wire logic bottom_ev,
  input wire logic fast_mode,
  input wire logic non_pwm,
  // controls
  input wire logic [1:0] action,
  input wire logic pin_dir,
  input wire logic port_dat,
  // pin
  output logic pin_o,
  output logic pin_oe
);
  logic wave_r;

  // internal compare output state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_r <= 1'b0;
    end else if (clk_en) begin
      if (action == tmw_pkg::ACT_NONE) begin
        wave_r <= wave_r;
      end else if (non_pwm && match_ev && action == tmw_pkg::ACT_TOGGLE) begin
        wave_r <= ~wave_r;
      end else if (non_pwm && match_ev) begin
        wave_r <= (action == tmw_pkg::ACT_SET);
      end else if (fast_mode && action[1] && match_ev) begin
        wave_r <= action[0];
      end else if (fast_mode && action[1] && bottom_ev) begin
        wave_r <= ~action[0];
      end
    end
  end

  // pin override only when the action field is live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (clk_en) begin
      pin_o <= (action != tmw_pkg::ACT_NONE) ? wave_r : port_dat;
      pin_oe <= pin_dir;
    end
  end
endmodule
`default_nettype wire

// file: rtl/tmw_ahb_if.sv
/*
  AHB-Lite slave front end: captures the address phase and yields a
  one-cycle write or read strobe in the data phase. Zero wait states.
  Assumes single word transfers; response is always OKAY.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_ahb_if (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // strobes
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_addr
);
  // latch address phase; nonseq or seq both accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      reg_addr <= 8'h00;
    end else if (clk_en) begin
      wr_stb <= hsel && hready && htrans[1] && hwrite;
      rd_stb <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) begin
        reg_addr <= haddr[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/tmw_timer.sv
/*
  16-bit timer with normal, clear-on-match and fast pwm counting,
  flags, two compare outputs, and an AHB-Lite register slave.
  Assumes tmr_en is a prescaled one-cycle enable in the hclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_timer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // prescaled timer enable
  input wire logic tmr_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // compare pins
  output logic wave_out_a_o,
  output logic wave_out_a_oe,
  output logic wave_out_b_o,
  output logic wave_out_b_oe
);
  // ****************************************
  // declarations
  // ****************************************
  logic wr_stb;
  logic [7:0] reg_addr;
  logic [7:0] ctrl_r;
  logic [15:0] count_register_r;
  logic [15:0] count_nxt;
  logic [15:0] compare_reg_a_r;
  logic [15:0] cmpa_buf_r;
  logic [15:0] compare_reg_b_r;
  logic [15:0] capture_register_r;
  logic [3:0] flags_r;
  logic [3:0] port_r;
  logic [15:0] top;
  logic [15:0] mask;
  logic block_r;
  logic at_top;
  logic match_a;
  logic match_b;
  logic ev_top;
  logic ev_wrap;
  logic [3:0] waveform_mode_field;
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  tmw_pkg::tmw_class_t cls;

  assign waveform_mode_field = ctrl_r[tmw_pkg::CTRL_WAVE_LSB +: 4];
  assign output_action_a = ctrl_r[tmw_pkg::CTRL_ACTA_LSB +: 2];
  assign output_action_b = ctrl_r[tmw_pkg::CTRL_ACTB_LSB +: 2];
  // class from mode alone; action fields never enter here
  assign cls = tmw_pkg::tmw_class(waveform_mode_field);

  tmw_ahb_if u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_stb(wr_stb),
    .rd_stb(),
    .reg_addr(reg_addr)
  );

  // ****************************************
  // top select and match decode
  // ****************************************
  always_comb begin
    mask = tmw_pkg::CNT_MAX;
    unique case (waveform_mode_field)
      tmw_pkg::WM_CTC_A: top = compare_reg_a_r;
      tmw_pkg::WM_CTC_CAP: top = capture_register_r;
      tmw_pkg::WM_FAST_8: begin
        top = tmw_pkg::TOP_8;
        mask = tmw_pkg::TOP_8;
      end
      tmw_pkg::WM_FAST_9: begin
        top = tmw_pkg::TOP_9;
        mask = tmw_pkg::TOP_9;
      end
      tmw_pkg::WM_FAST_10: begin
        top = tmw_pkg::TOP_10;
        mask = tmw_pkg::TOP_10;
      end
      tmw_pkg::WM_FAST_CAP: top = capture_register_r;
      tmw_pkg::WM_FAST_A: top = compare_reg_a_r;
      default: top = tmw_pkg::CNT_MAX;
    endcase
  end

  // a counter write blocks matches for one timer cycle
  assign at_top = (count_register_r == top) && !block_r;
  assign match_a = (count_register_r == compare_reg_a_r) && !block_r;
  assign match_b = (count_register_r == compare_reg_b_r) && !block_r;
  assign ev_top = tmr_en && at_top &&
                  (cls == tmw_pkg::TMW_CLEAR_MATCH || cls == tmw_pkg::TMW_FAST);
  // wrap from max to zero, any mode that lets the count pass 0xffff;
  // a held counter never wraps, so undecoded modes raise no overflow
  assign ev_wrap = tmr_en && count_register_r == tmw_pkg::CNT_MAX &&
                   cls != tmw_pkg::TMW_OTHER &&
                   !(ev_top && cls == tmw_pkg::TMW_FAST);

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    count_nxt = count_register_r + 16'h0001;
    if (ev_top) begin
      count_nxt = tmw_pkg::CNT_RESET;
    end
  end

  // count, with software write accepted at any moment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_register_r <= tmw_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (wr_stb && reg_addr == tmw_pkg::ADDR_COUNT) begin
        count_register_r <= hwdata[15:0];
      end else if (tmr_en && cls != tmw_pkg::TMW_OTHER) begin
        count_register_r <= count_nxt;
      end
    end
  end

  // match blocking after a counter write, cleared on the next tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_stb && reg_addr == tmw_pkg::ADDR_COUNT) begin
        block_r <= 1'b1;
      end else if (tmr_en) begin
        block_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // compare and capture registers
  // ****************************************
  // non-pwm writes go straight in; pwm writes go to the buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_reg_a_r <= tmw_pkg::CNT_RESET;
      cmpa_buf_r <= tmw_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (wr_stb && reg_addr == tmw_pkg::ADDR_CMPA) begin
        cmpa_buf_r <= hwdata[15:0] & mask;
        if (cls != tmw_pkg::TMW_FAST) begin
          compare_reg_a_r <= hwdata[15:0] & mask;
        end
      end
      if (cls == tmw_pkg::TMW_FAST && ev_top) begin
        compare_reg_a_r <= cmpa_buf_r;
      end
    end
  end

  // channel b and capture register; b unbuffered for brevity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_reg_b_r <= tmw_pkg::CNT_RESET;
      capture_register_r <= tmw_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (wr_stb && reg_addr == tmw_pkg::ADDR_CMPB) begin
        compare_reg_b_r <= hwdata[15:0] & mask;
      end
      if (wr_stb && reg_addr == tmw_pkg::ADDR_CAPT) begin
        capture_register_r <= hwdata[15:0];
      end
    end
  end

  // ****************************************
  // control, port and flags
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 8'h00;
      port_r <= 4'h0;
    end else if (clk_en) begin
      if (wr_stb && reg_addr == tmw_pkg::ADDR_CTRL) begin
        ctrl_r <= hwdata[7:0];
      end
      if (wr_stb && reg_addr == tmw_pkg::ADDR_PORT) begin
        port_r <= hwdata[3:0];
      end
    end
  end

  // flags: set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_stb && reg_addr == tmw_pkg::ADDR_FLAGS && hwdata[i]) begin
          flags_r[i] <= 1'b0;
        end
      end
      if ((cls == tmw_pkg::TMW_FAST && ev_top) ||
          (cls != tmw_pkg::TMW_FAST && ev_wrap)) begin
        flags_r[tmw_pkg::FLAG_OVF] <= 1'b1;
      end
      if (tmr_en && match_a) begin
        flags_r[tmw_pkg::FLAG_CMPA] <= 1'b1;
      end
      if (tmr_en && match_b) begin
        flags_r[tmw_pkg::FLAG_CMPB] <= 1'b1;
      end
      if (ev_top && (waveform_mode_field == tmw_pkg::WM_CTC_CAP ||
                     waveform_mode_field == tmw_pkg::WM_FAST_CAP)) begin
        flags_r[tmw_pkg::FLAG_CAPT] <= 1'b1;
      end
    end
  end

  // ****************************************
  // register read and bus answer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      unique case (haddr[7:0])
        tmw_pkg::ADDR_CTRL: hrdata <= {24'h000000, ctrl_r};
        tmw_pkg::ADDR_COUNT: hrdata <= {16'h0000, count_register_r};
        tmw_pkg::ADDR_CMPA: hrdata <= {16'h0000, cmpa_buf_r};
        tmw_pkg::ADDR_CMPB: hrdata <= {16'h0000, compare_reg_b_r};
        tmw_pkg::ADDR_CAPT: hrdata <= {16'h0000, capture_register_r};
        tmw_pkg::ADDR_FLAGS: hrdata <= {28'h0000000, flags_r};
        tmw_pkg::ADDR_PORT: hrdata <= {28'h0000000, port_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // compare outputs
  // ****************************************
  tmw_wave_out u_out_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .match_ev(tmr_en && match_a),
    .bottom_ev(ev_top),
    .fast_mode(cls == tmw_pkg::TMW_FAST),
    .non_pwm(cls == tmw_pkg::TMW_NORMAL || cls == tmw_pkg::TMW_CLEAR_MATCH),
    .action(output_action_a),
    .pin_dir(port_r[tmw_pkg::PORT_DIR_A]),
    .port_dat(port_r[tmw_pkg::PORT_DAT_A]),
    .pin_o(wave_out_a_o),
    .pin_oe(wave_out_a_oe)
  );

  tmw_wave_out u_out_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .match_ev(tmr_en && match_b),
    .bottom_ev(ev_top),
    .fast_mode(cls == tmw_pkg::TMW_FAST),
    .non_pwm(cls == tmw_pkg::TMW_NORMAL || cls == tmw_pkg::TMW_CLEAR_MATCH),
    .action(output_action_b),
    .pin_dir(port_r[tmw_pkg::PORT_DIR_B]),
    .port_dat(port_r[tmw_pkg::PORT_DAT_B]),
    .pin_o(wave_out_b_o),
    .pin_oe(wave_out_b_oe)
  );

  // ****************************************
  // checks
  // ****************************************
  chk_normal_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && tmr_en && cls == tmw_pkg::TMW_NORMAL && !wr_stb &&
    count_register_r == tmw_pkg::CNT_MAX |=> count_register_r == 16'h0000)
    else $error("normal mode did not wrap to zero");
  chk_ovf_normal: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && tmr_en && cls == tmw_pkg::TMW_NORMAL &&
    count_register_r == tmw_pkg::CNT_MAX |=> flags_r[tmw_pkg::FLAG_OVF])
    else $error("overflow flag not set at wrap");
  chk_count_write: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_stb && reg_addr == tmw_pkg::ADDR_COUNT
    |=> count_register_r == $past(hwdata[15:0]))
    else $error("counter write lost");
  chk_ctc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && tmr_en && !wr_stb && cls == tmw_pkg::TMW_CLEAR_MATCH && at_top
    |=> count_register_r == 16'h0000)
    else $error("clear-on-match did not clear");
  chk_top_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ev_top && waveform_mode_field == tmw_pkg::WM_CTC_A
    |=> flags_r[tmw_pkg::FLAG_CMPA])
    else $error("compare a flag missing at top");
  chk_fast_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ev_top && cls == tmw_pkg::TMW_FAST
    |=> flags_r[tmw_pkg::FLAG_OVF])
    else $error("fast pwm overflow flag missing");
  chk_buf_load: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ev_top && cls == tmw_pkg::TMW_FAST
    |=> compare_reg_a_r == $past(cmpa_buf_r))
    else $error("compare a buffer not loaded at top");
  chk_hold_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !tmr_en && !wr_stb |=> $stable(count_register_r))
    else $error("counter moved without timer enable");
  chk_pin_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> wave_out_a_oe == $past(port_r[tmw_pkg::PORT_DIR_A]))
    else $error("pin enable does not follow direction bit");
endmodule
`default_nettype wire

// file: tb/tmw_pin_load.sv
/*
  Load on one compare pin: resolves the level that outside circuitry sees.
  Assumes the pin has no pull, so a released line shows the inverse of its last driven value.
*/
`timescale 1ns/1ps
`default_nettype none
module tmw_pin_load (
  // clock
  input wire logic hclk,
  // pin from the timer
  input wire logic pin_o,
  input wire logic pin_oe,
  // level seen outside
  output var logic level
);
  // ****************************************
  // wire resolution
  // ****************************************
  logic last_r;
  initial last_r = 1'b0;
  // remember the last driven value so a released line cannot fake it
  always @(posedge hclk) begin
    if (pin_oe) begin
      last_r <= pin_o;
    end
  end
  // released line shows the inverse, never a stale copy
  always_comb level = pin_oe ? pin_o : ~last_r;
endmodule
`default_nettype wire

// file: tb/tb_timer16_wave_modes.sv
/*
  Self-checking bench for the timer wave block over AHB-Lite.
  Assumes zero wait states are possible but never relied on.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_wave_modes;
  // ****************************************
  // signals
  // ****************************************
  logic hclk = 1'b0, hresetn = 1'b0, tmr_en = 1'b0, hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, wa_o, wa_oe, wb_o, wb_oe, level_a, rd_dp;
  logic [31:0] exp_q[$];
  int fail_count = 0, cmp_count = 0, seed = 57998;
  logic [15:0] v;
  logic [15:0] tops[3] = '{tmw_pkg::TOP_8, tmw_pkg::TOP_9, tmw_pkg::TOP_10};

  tmw_timer tmw_timer_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .tmr_en(tmr_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wave_out_a_o(wa_o), .wave_out_a_oe(wa_oe), .wave_out_b_o(wb_o),
    .wave_out_b_oe(wb_oe));
  tmw_pin_load tmw_pin_load_i (.hclk(hclk), .pin_o(wa_o), .pin_oe(wa_oe),
    .level(level_a));

  // ****************************************
  // clock, checks and verdict
  // ****************************************
  initial forever #5 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // read results are compared when the data phase completes
  initial rd_dp = 1'b0;
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1) begin
      rd_dp = hsel && htrans[1] && !hwrite;
    end
  end

  // a hang past the planned run is a failure
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end

  // ****************************************
  // bus and timer tasks
  // ****************************************
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  // the expectation is noted before the address phase goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask

  // n back-to-back timer ticks, then a few cycles for the pins to settle
  task automatic tick(input int n);
    @(posedge hclk);
    tmr_en <= 1'b1;
    repeat (n) @(posedge hclk);
    tmr_en <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  // start a period: counter value and cleared flags
  task automatic arm(input logic [15:0] c);
    wr(tmw_pkg::ADDR_COUNT, {16'h0, c});
    wr(tmw_pkg::ADDR_FLAGS, 32'hf);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h0);
    rd(8'h1c, 32'h0);
    // normal mode; action bits set to show they leave the sequence alone
    wr(tmw_pkg::ADDR_CTRL, 32'h30);
    v = 16'hff00 | 16'($random(seed) & 8'hff);
    wr(tmw_pkg::ADDR_COUNT, {16'h0, v});
    rd(tmw_pkg::ADDR_COUNT, {16'h0, v});
    arm(16'hfffe);
    tick(2);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h1);
    repeat (5) @(posedge hclk);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    // clear on compare a with toggle, pin driven out
    wr(tmw_pkg::ADDR_CMPA, 32'h5);
    wr(tmw_pkg::ADDR_CTRL, 32'h14);
    wr(tmw_pkg::ADDR_PORT, 32'h1);
    arm(16'h0);
    tick(6);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h2);
    check({31'h0, level_a}, 32'h1);
    check({31'h0, wa_oe}, 32'h1);
    tick(6);
    check({31'h0, wa_o}, 32'h0);
    // action 0: port data on the pin, wave state kept through a match
    wr(tmw_pkg::ADDR_CTRL, 32'h04);
    wr(tmw_pkg::ADDR_PORT, 32'h5);
    tick(6);
    check({31'h0, wa_o}, 32'h1);
    wr(tmw_pkg::ADDR_CTRL, 32'h14);
    repeat (3) @(posedge hclk);
    check({31'h0, wa_o}, 32'h0);
    wr(tmw_pkg::ADDR_PORT, 32'h4);
    repeat (3) @(posedge hclk);
    check({31'h0, wa_oe}, 32'h0);
    wr(tmw_pkg::ADDR_PORT, 32'h1);
    // clear on capture register
    wr(tmw_pkg::ADDR_CAPT, 32'h3);
    wr(tmw_pkg::ADDR_CTRL, 32'h0c);
    arm(16'h0);
    tick(4);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h8);
    // top written below the count: run through max and wrap
    wr(tmw_pkg::ADDR_CTRL, 32'h04);
    arm(16'h8);
    wr(tmw_pkg::ADDR_CMPA, 32'h3);
    tick(65530);
    rd(tmw_pkg::ADDR_COUNT, 32'h2);
    rd(tmw_pkg::ADDR_FLAGS, 32'h5);
    // fast pwm, fixed 8-bit top, a non-inverting, b inverting
    wr(tmw_pkg::ADDR_CTRL, 32'he5);
    wr(tmw_pkg::ADDR_CMPA, 32'h1234);
    rd(tmw_pkg::ADDR_CMPA, 32'h34);
    arm(16'hfe);
    tick(2);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h1);
    check({31'h0, wa_o}, 32'h1);
    check({31'h0, wb_o}, 32'h0);
    tick(16'h35);
    check({31'h0, wa_o}, 32'h0);
    check({31'h0, wb_o}, 32'h1);
    check({31'h0, wb_oe}, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h7);
    // remaining fixed tops
    for (int i = 1; i < 3; i++) begin
      wr(tmw_pkg::ADDR_CTRL, 32'h25 + i);
      arm(tops[i] - 16'h1);
      tick(2);
      rd(tmw_pkg::ADDR_COUNT, 32'h0);
      rd(tmw_pkg::ADDR_FLAGS, 32'h1);
    end
    // top from capture register
    wr(tmw_pkg::ADDR_CAPT, 32'h20);
    wr(tmw_pkg::ADDR_CTRL, 32'h2e);
    arm(16'h1f);
    tick(2);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h9);
    // top from compare a: new value waits in the buffer until top
    wr(tmw_pkg::ADDR_CTRL, 32'h2f);
    wr(tmw_pkg::ADDR_CMPA, 32'h40);
    arm(16'h30);
    tick(5);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    rd(tmw_pkg::ADDR_FLAGS, 32'h3);
    arm(16'h3f);
    tick(2);
    rd(tmw_pkg::ADDR_COUNT, 32'h0);
    repeat (2) @(posedge hclk);
    give_verdict();
  end
endmodule
`default_nettype wire
